// File: shared/gsr_pkg.sv
// constants and types shared by the sensor end and the timing controller end
// What this block does
// - all pixels reset together for common integration
// - all pixels sampled to storage at once
// - readout proceeds one row at a time
// - pipelined mode overlaps integration with prior readout
// - frame readout opens with frame overhead interval
// - row overhead interval precedes each row readout
// - nondestructive mode reads pixels repeatedly without reset
// - power-up flushes 1024 column, 2048 row pulses
// - latched-up device recovers once clocked
// - controller starts clocking right after power-on
// - seven-bit value sets output dc reference
// - one bit selects one or two outputs
// - frame sync starts frame, resyncs row address
// - row step clock rising edge selects next row
// - line sync starts row at column start rounded down to even
// - column clock set for 33 MHz runs at 50 MHz after the divider, giving 100 MHz pixels
package gsr_pkg;
    localparam int CLK_MHZ = 100;
    localparam int FLUSH_COLS = 1024;
    localparam int FLUSH_ROWS = 2048;
    localparam int FRAME_OVH_NS = 5000;
    localparam int ROW_OVH_NS = 200;
    localparam int FRAME_OVH_CYC = (FRAME_OVH_NS * CLK_MHZ + 999) / 1000;
    localparam int ROW_OVH_CYC = (ROW_OVH_NS * CLK_MHZ + 999) / 1000;
    localparam int COL_CLK_MHZ = 33;
    // column clock half period in reference cycles, rounded down, not clamped, so it is 0 when COL_CLK_MHZ exceeds half of CLK_MHZ
    localparam int COL_HALF_CYC = CLK_MHZ / (2 * COL_CLK_MHZ);
    localparam int DC_REF_W = 7;
    localparam logic [6:0] DC_REF_RESET = 7'h40;
    localparam int ROWS = 2048;
    localparam int COLS = 2048;
    localparam int ADDR_W = 11;
    typedef enum logic [3:0]
    {
        GSR_POWER = 4'h0,
        GSR_FLUSH = 4'h1,
        GSR_SUPPLY = 4'h2,
        GSR_RESET = 4'h3,
        GSR_INTEG = 4'h4,
        GSR_FOH = 4'h5,
        GSR_ROH = 4'h6,
        GSR_LINE = 4'h7,
        GSR_NEXT = 4'h8,
        GSR_IDLE = 4'h9
    } gsr_state_e;
endpackage

// File: shared/gsr_if.sv
// link between sensor readout end and external timing controller end
interface gsr_if;
    logic vdd_on;
    logic supplies_on;
    logic col_clk;
    logic row_clk;
    logic frame_sync;
    logic line_sync;
    logic pixel_reset;
    logic pixel_sample;
    logic [6:0] dc_ref;
    logic dual_out;
    logic ndr_mode;
    logic latched;
    logic [10:0] row_addr;
    logic [10:0] col_addr;
    logic pix_valid;
    modport sensor
    (
        input vdd_on, supplies_on, col_clk, row_clk, frame_sync, line_sync,
        input pixel_reset, pixel_sample, dc_ref, dual_out, ndr_mode,
        output latched, row_addr, col_addr, pix_valid
    );
    modport ctrl
    (
        output vdd_on, supplies_on, col_clk, row_clk, frame_sync, line_sync,
        output pixel_reset, pixel_sample, dc_ref, dual_out, ndr_mode,
        input latched, row_addr, col_addr, pix_valid
    );
endinterface

// File: verilog/gsr_sensor.sv
// sensor end: pixel array state, row and column addressing, output setup
module gsr_sensor
#(
    parameter int ROWS = gsr_pkg::ROWS,
    parameter int COLS = gsr_pkg::COLS
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    gsr_if.sensor link,
    input wire logic [10:0] col_start_in,
    output logic integrating_out,
    output logic stored_valid_out,
    output logic [6:0] dc_level_out,
    output logic out2_enable_out,
    output logic latched_out,
    output logic [10:0] row_addr_out,
    output logic [10:0] col_addr_out,
    output logic pix_valid_out
);
    // link signals are same-clock logic, so no synchronisers
    logic row_clk_d_reg;
    logic col_clk_d_reg;
    logic row_rise;
    logic col_rise;
    logic [10:0] row_reg;
    logic [10:0] col_reg;
    logic line_active_reg;
    assign row_rise = link.row_clk & ~row_clk_d_reg;
    assign col_rise = link.col_clk & ~col_clk_d_reg;

    always_ff @(posedge ref_clk_in)
    begin
        row_clk_d_reg <= reset_in ? 1'b0 : link.row_clk;
        col_clk_d_reg <= reset_in ? 1'b0 : link.col_clk;
    end

    // latch-up when the other supplies are on while vdd is off; cleared by clocks
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            latched_out <= 1'b0;
        else if (row_rise || col_rise)
            latched_out <= 1'b0;
        else if (link.supplies_on && !link.vdd_on)
            latched_out <= 1'b1;
    end

    // whole array reset and sampled as one
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            integrating_out <= 1'b0;
            stored_valid_out <= 1'b0;
        end
        else
        begin
            if (link.pixel_reset)
                integrating_out <= 1'b1;
            if (link.pixel_sample)
            begin
                stored_valid_out <= 1'b1;
                // nondestructive: integration carries on after the sample
                if (!link.ndr_mode)
                    integrating_out <= link.pixel_reset;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            row_reg <= '0;
        else if (link.frame_sync)
            row_reg <= '0;
        else if (row_rise)
            row_reg <= (row_reg == 11'(ROWS - 1)) ? '0 : row_reg + 11'h001;
    end

    // two outputs carry two pixels per column clock rising edge
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            col_reg <= '0;
            line_active_reg <= 1'b0;
        end
        else if (link.line_sync)
        begin
            col_reg <= {col_start_in[10:1], 1'b0};
            line_active_reg <= 1'b1;
        end
        else if (col_rise && line_active_reg)
        begin
            if (col_reg >= 11'(COLS - 2))
                line_active_reg <= 1'b0;
            col_reg <= col_reg + 11'h002;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            dc_level_out <= gsr_pkg::DC_REF_RESET;
            out2_enable_out <= 1'b0;
            row_addr_out <= '0;
            col_addr_out <= '0;
            pix_valid_out <= 1'b0;
        end
        else
        begin
            dc_level_out <= link.dc_ref;
            out2_enable_out <= link.dual_out;
            row_addr_out <= row_reg;
            col_addr_out <= col_reg;
            pix_valid_out <= line_active_reg & col_rise & stored_valid_out;
        end
    end

    assign link.latched = latched_out;
    assign link.row_addr = row_addr_out;
    assign link.col_addr = col_addr_out;
    assign link.pix_valid = pix_valid_out;
endmodule

// File: verilog/gsr_ctrl.sv
// timing controller end: power-up flush, exposure and row-by-row readout
module gsr_ctrl
#(
    parameter int ROWS = gsr_pkg::ROWS,
    parameter int COLS = gsr_pkg::COLS,
    parameter int FLUSH_COLS = gsr_pkg::FLUSH_COLS,
    parameter int FLUSH_ROWS = gsr_pkg::FLUSH_ROWS,
    parameter int INTEG_CYC = 1000
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    gsr_if.ctrl link,
    input wire logic start_in,
    input wire logic pipelined_in,
    input wire logic ndr_in,
    input wire logic dual_out_in,
    input wire logic [6:0] dc_ref_in,
    input wire logic [15:0] frame_ovh_in,
    input wire logic [15:0] row_ovh_in,
    output logic ready_out,
    output logic busy_out,
    output logic frame_done_out
);
    gsr_pkg::gsr_state_e state_reg;
    logic [15:0] cnt_reg;
    logic [11:0] row_cnt_reg;
    logic [11:0] col_cnt_reg;
    logic [11:0] row_flush_reg;
    logic [3:0] div_reg;
    logic col_clk_reg;
    logic row_clk_reg;
    logic [31:0] integ_reg;
    logic half_tick;
    assign half_tick = (div_reg == 4'(gsr_pkg::COL_HALF_CYC - 1));

    // column clock from a divider that runs from reset on; the clock toggles only in GSR_FLUSH and GSR_LINE
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            div_reg <= '0;
        else
            div_reg <= half_tick ? '0 : div_reg + 4'h1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            integ_reg <= '0;
        // exposure is timed from the reset pulse, or from the frame overhead
        // where the next exposure overlaps this readout
        else if (state_reg == gsr_pkg::GSR_IDLE ||
            state_reg == gsr_pkg::GSR_RESET || state_reg == gsr_pkg::GSR_FOH)
            integ_reg <= '0;
        else if (integ_reg != 32'(INTEG_CYC))
            integ_reg <= integ_reg + 32'h1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            state_reg <= gsr_pkg::GSR_POWER;
            cnt_reg <= '0;
            row_cnt_reg <= '0;
            col_cnt_reg <= '0;
            row_flush_reg <= '0;
            col_clk_reg <= 1'b0;
            row_clk_reg <= 1'b0;
            link.vdd_on <= 1'b0;
            link.supplies_on <= 1'b0;
            link.frame_sync <= 1'b0;
            link.line_sync <= 1'b0;
            link.pixel_reset <= 1'b0;
            link.pixel_sample <= 1'b0;
            ready_out <= 1'b0;
            busy_out <= 1'b0;
            frame_done_out <= 1'b0;
        end
        else
        begin
            link.frame_sync <= 1'b0;
            link.line_sync <= 1'b0;
            link.pixel_reset <= 1'b0;
            link.pixel_sample <= 1'b0;
            frame_done_out <= 1'b0;
            unique case (state_reg)
                gsr_pkg::GSR_POWER:
                begin
                    link.vdd_on <= 1'b1;
                    state_reg <= gsr_pkg::GSR_FLUSH;
                end
                gsr_pkg::GSR_FLUSH:
                begin
                    // each clock counts its own rises and parks low at its
                    // count, so the shorter column flush cannot restart
                    if (half_tick)
                    begin
                        if (col_clk_reg)
                            col_clk_reg <= 1'b0;
                        else if (col_cnt_reg != 12'(FLUSH_COLS))
                        begin
                            col_clk_reg <= 1'b1;
                            col_cnt_reg <= col_cnt_reg + 12'h001;
                        end
                        if (row_clk_reg)
                            row_clk_reg <= 1'b0;
                        else if (row_flush_reg != 12'(FLUSH_ROWS))
                        begin
                            row_clk_reg <= 1'b1;
                            row_flush_reg <= row_flush_reg + 12'h001;
                        end
                    end
                    if (col_cnt_reg == 12'(FLUSH_COLS) && !col_clk_reg &&
                        row_flush_reg == 12'(FLUSH_ROWS) && !row_clk_reg)
                        state_reg <= gsr_pkg::GSR_SUPPLY;
                end
                gsr_pkg::GSR_SUPPLY:
                begin
                    link.supplies_on <= 1'b1;
                    ready_out <= 1'b1;
                    state_reg <= gsr_pkg::GSR_IDLE;
                end
                gsr_pkg::GSR_IDLE:
                    if (start_in)
                    begin
                        busy_out <= 1'b1;
                        link.pixel_reset <= 1'b1;
                        state_reg <= gsr_pkg::GSR_INTEG;
                    end
                gsr_pkg::GSR_RESET:
                begin
                    link.pixel_reset <= 1'b1;
                    state_reg <= gsr_pkg::GSR_INTEG;
                end
                gsr_pkg::GSR_INTEG:
                    if (integ_reg == 32'(INTEG_CYC))
                    begin
                        link.pixel_sample <= 1'b1;
                        link.frame_sync <= 1'b1;
                        cnt_reg <= frame_ovh_in;
                        row_cnt_reg <= '0;
                        state_reg <= gsr_pkg::GSR_FOH;
                    end
                gsr_pkg::GSR_FOH:
                begin
                    // pipelined: next frame's exposure restarts here
                    if (pipelined_in && !ndr_in)
                        link.pixel_reset <= 1'b1;
                    cnt_reg <= row_ovh_in;
                    if (cnt_reg <= 16'h0001)
                        state_reg <= gsr_pkg::GSR_ROH;
                    else
                        cnt_reg <= cnt_reg - 16'h0001;
                end
                gsr_pkg::GSR_ROH:
                    if (cnt_reg <= 16'h0001)
                    begin
                        link.line_sync <= 1'b1;
                        col_cnt_reg <= '0;
                        state_reg <= gsr_pkg::GSR_LINE;
                    end
                    else
                        cnt_reg <= cnt_reg - 16'h0001;
                gsr_pkg::GSR_LINE:
                    if (half_tick)
                    begin
                        col_clk_reg <= ~col_clk_reg;
                        if (!col_clk_reg)
                            col_cnt_reg <= col_cnt_reg + 12'h002;
                        if (col_clk_reg && col_cnt_reg >= 12'(COLS))
                        begin
                            row_clk_reg <= 1'b1;
                            state_reg <= gsr_pkg::GSR_NEXT;
                        end
                    end
                gsr_pkg::GSR_NEXT:
                begin
                    row_clk_reg <= 1'b0;
                    cnt_reg <= row_ovh_in;
                    row_cnt_reg <= row_cnt_reg + 12'h001;
                    if (row_cnt_reg == 12'(ROWS - 1))
                    begin
                        frame_done_out <= 1'b1;
                        busy_out <= start_in;
                        // nondestructive reads again without a new reset
                        if (!start_in)
                            state_reg <= gsr_pkg::GSR_IDLE;
                        else if (ndr_in || pipelined_in)
                            state_reg <= gsr_pkg::GSR_INTEG;
                        else
                            state_reg <= gsr_pkg::GSR_RESET;
                    end
                    else
                        state_reg <= gsr_pkg::GSR_ROH;
                end
                default:
                    state_reg <= gsr_pkg::GSR_POWER;
            endcase
        end
    end

    assign link.col_clk = col_clk_reg;
    assign link.row_clk = row_clk_reg;
    assign link.dc_ref = dc_ref_in;
    assign link.dual_out = dual_out_in;
    assign link.ndr_mode = ndr_in;
endmodule

// File: bench/gsr_link_properties.sv
// concurrent checks on the link between the sensor and timing controller
module gsr_link_properties
#(
    parameter int FLUSH_COLS = 1024,
    parameter int FLUSH_ROWS = 2048
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic vdd_on,
    input wire logic supplies_on,
    input wire logic col_clk,
    input wire logic row_clk,
    input wire logic frame_sync,
    input wire logic line_sync,
    input wire logic pixel_reset,
    input wire logic pixel_sample,
    input wire logic [10:0] row_addr,
    input wire logic [10:0] col_addr,
    input wire logic pix_valid
);
    int col_rises;
    int row_rises;
    logic col_prev;
    logic row_prev;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    // only rises before the other supplies count toward the flush
    always_ff @(posedge ref_clk_in)
    begin
        col_prev <= reset_in ? 1'b0 : col_clk;
        row_prev <= reset_in ? 1'b0 : row_clk;
        if (reset_in)
        begin
            col_rises <= 0;
            row_rises <= 0;
        end
        else if (!supplies_on)
        begin
            col_rises <= col_rises + int'(col_clk && !col_prev);
            row_rises <= row_rises + int'(row_clk && !row_prev);
        end
    end

    a_sample_with_sync: assert property (frame_sync |-> pixel_sample)
        else $error("frame sync without storage sample");
    a_sync_needs_power: assert property (
        frame_sync |-> vdd_on && supplies_on)
        else $error("frame sync before supplies are up");
    a_supply_order: assert property ($rose(supplies_on) |-> vdd_on)
        else $error("supplies raised before digital supply");
    a_flush_rows: assert property (
        $rose(supplies_on) |-> row_rises == FLUSH_ROWS)
        else $error("wrong row flush count");
    a_flush_cols: assert property (
        $rose(supplies_on) |-> col_rises == FLUSH_COLS)
        else $error("wrong column flush count");
    a_clk_after_vdd: assert property (
        $rose(col_clk) || $rose(row_clk) |-> vdd_on)
        else $error("clock before digital supply");
    a_overhead_gap: assert property (
        frame_sync |=> (!line_sync && !pix_valid) [*2])
        else $error("row read inside frame overhead");
    a_pix_single: assert property (pix_valid |=> !pix_valid)
        else $error("pixel strobe longer than one cycle");
    a_col_pairs: assert property (
        pix_valid ##2 pix_valid |-> col_addr == $past(col_addr, 2) + 11'h2)
        else $error("column address did not step by two");
    // the address output lags the row register by one cycle
    a_row_resync: assert property (
        frame_sync |-> ##2 row_addr == 11'h0)
        else $error("row address not resynchronised");
    a_row_step: assert property (
        $rose(row_clk) && supplies_on |-> ##2 row_addr != $past(row_addr, 2))
        else $error("row clock rise did not select a new row");

    c_frame: cover property (frame_sync);
    c_pixel_pair: cover property (pix_valid ##2 pix_valid);
    c_reset: cover property (pixel_reset);
    c_power: cover property ($rose(supplies_on));
endmodule

// File: bench/test_global_shutter_readout_sequencer.sv
// self-checking bench: sensor and controller joined, frames in each mode
module test_global_shutter_readout_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int R = 4;
    localparam int C = 8;
    typedef struct packed
    {
        logic p;
        logic n;
        logic d;
        logic [6:0] dc;
        logic [15:0] fo;
        logic [15:0] ro;
    } gsr_row_s;
    gsr_row_s rows [4] = '{
        '{1'b0, 1'b0, 1'b0, 7'h00, 16'h3, 16'h1},
        '{1'b0, 1'b0, 1'b1, 7'h7f, 16'h1, 16'h2},
        '{1'b1, 1'b0, 1'b0, 7'h2a, 16'h4, 16'h1},
        '{1'b0, 1'b1, 1'b1, 7'h55, 16'h2, 16'h3}};
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic start_in = 1'b0;
    logic pipelined_in = 1'b0;
    logic ndr_in = 1'b0;
    logic dual_out_in = 1'b0;
    logic [6:0] dc_ref_in = 7'h00;
    logic [15:0] frame_ovh_in = 16'h1;
    logic [15:0] row_ovh_in = 16'h1;
    logic [10:0] col_start_in = 11'h0;
    logic integrating, stored_valid, out2_enable, latched;
    logic ready, busy, frame_done, integ_at_line;
    logic [6:0] dc_level;
    logic [10:0] first_col;
    int n_errors = 0;
    int n_tests = 0;
    int n_pix, n_line, n_rst, gap;

    gsr_if link_if();
    gsr_sensor #(.ROWS(R), .COLS(C)) gsr_sensor_i
    (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .link(link_if),
        .col_start_in(col_start_in), .integrating_out(integrating),
        .stored_valid_out(stored_valid), .dc_level_out(dc_level),
        .out2_enable_out(out2_enable), .latched_out(latched),
        .row_addr_out(), .col_addr_out(), .pix_valid_out()
    );
    gsr_ctrl #(.ROWS(R), .COLS(C), .FLUSH_COLS(8), .FLUSH_ROWS(16),
        .INTEG_CYC(20)) gsr_ctrl_i
    (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .link(link_if),
        .start_in(start_in), .pipelined_in(pipelined_in), .ndr_in(ndr_in),
        .dual_out_in(dual_out_in), .dc_ref_in(dc_ref_in),
        .frame_ovh_in(frame_ovh_in), .row_ovh_in(row_ovh_in),
        .ready_out(ready), .busy_out(busy), .frame_done_out(frame_done)
    );
    gsr_link_properties #(.FLUSH_COLS(8), .FLUSH_ROWS(16)) props_i
    (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .vdd_on(link_if.vdd_on), .supplies_on(link_if.supplies_on),
        .col_clk(link_if.col_clk), .row_clk(link_if.row_clk),
        .frame_sync(link_if.frame_sync), .line_sync(link_if.line_sync),
        .pixel_reset(link_if.pixel_reset),
        .pixel_sample(link_if.pixel_sample), .row_addr(link_if.row_addr),
        .col_addr(link_if.col_addr), .pix_valid(link_if.pix_valid)
    );

    initial
    begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
    begin
        if (link_if.pix_valid && n_pix == 0)
            first_col = link_if.col_addr;
        if (link_if.line_sync && n_line == 0)
            integ_at_line = integrating;
        gap = link_if.frame_sync ? 0 : gap + int'(n_line == 0);
        n_pix += int'(link_if.pix_valid);
        n_line += int'(link_if.line_sync);
        n_rst += int'(link_if.pixel_reset);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic run_frame(input gsr_row_s r, input logic exp_rst);
        int k;
        @(negedge ref_clk_in);
        {pipelined_in, ndr_in, dual_out_in, dc_ref_in} = {r.p, r.n, r.d, r.dc};
        {frame_ovh_in, row_ovh_in} = {r.fo, r.ro};
        {n_pix, n_line, n_rst, gap} = {32'h0, 32'h0, 32'h0, 32'h0};
        start_in = 1'b1;
        k = 0;
        while (busy !== 1'b1 && k < 100)
        begin
            @(negedge ref_clk_in);
            k++;
        end
        start_in = 1'b0;
        while (frame_done !== 1'b1)
            @(negedge ref_clk_in);
        check(n_pix, R * (C - int'({col_start_in[10:1], 1'b0})) / 2);
        check(n_line, R);
        check(gap >= r.fo + r.ro, 1);
        check(integ_at_line, r.p | r.n);
        check(out2_enable, r.d);
        check(dc_level, r.dc);
        check(stored_valid, 1);
        check(n_rst != 0, exp_rst);
        check(first_col, {col_start_in[10:1], 1'b0});
        $display("frame done: mode %b%b, errors %0d", r.p, r.n, n_errors);
    endtask

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (8) @(negedge ref_clk_in);
        check(dc_level, gsr_pkg::DC_REF_RESET);
        check(ready, 0);
        reset_in = 1'b0;
        start_in = 1'b1;
        // a start seen during the flush must be refused
        repeat (4) @(negedge ref_clk_in);
        start_in = 1'b0;
        check(busy, 0);
        while (ready !== 1'b1)
            @(negedge ref_clk_in);
        check(link_if.supplies_on, 1);
        check(latched, 0);
        $display("power-up test done");
        foreach (rows[i])
            run_frame(rows[i], 1'b1);
        col_start_in = 11'h5;
        run_frame(rows[3], 1'b1);
        // nondestructive: start held through the first frame, so a second unreset frame follows
        @(negedge ref_clk_in);
        {pipelined_in, ndr_in} = 2'b01;
        start_in = 1'b1;
        while (frame_done !== 1'b1)
            @(negedge ref_clk_in);
        start_in = 1'b0;
        {n_pix, n_rst} = {32'h0, 32'h0};
        @(negedge ref_clk_in);
        while (frame_done !== 1'b1)
            @(negedge ref_clk_in);
        check(n_rst, 0);
        check(integrating, 1);
        check(n_pix, R * (C - 4) / 2);
        check(first_col, 11'h4);
        $display("nondestructive test done");
        summarize();
    end
endmodule
